// >>> core/fag_cfg.svh
// Purpose: Constants for the flash access guard.
// Assumes: 64 kB program flash, 512-byte pages, 8 kB lock blocks.
// Notes:   Offsets are the special-register addresses of the core.
`ifndef FAG_CFG_SVH
`define FAG_CFG_SVH

// Special-register offsets
`define FAG_OFS_STORE 8'h8f
`define FAG_OFS_TIMING 8'hb7
`define FAG_OFS_LIMIT 8'hb8

// Reset values
`define FAG_RST_STORE 8'h00
`define FAG_RST_TIMING 8'h80
`define FAG_RST_LIMIT 8'h00

// Writable-bit masks; the rest read as zero
`define FAG_MASK_STORE 8'h07
`define FAG_MASK_TIMING 8'hc1

// Field positions
`define FAG_BIT_ONESHOT 7
`define FAG_BIT_EVERY 6
`define FAG_BIT_SWWE 0
`define FAG_BIT_SCRATCH 2
`define FAG_BIT_PERASE 1
`define FAG_BIT_PWRITE 0

// Flash geometry
`define FAG_WE_LOCK_ADDR 16'hfbfe
`define FAG_RD_LOCK_ADDR 16'hfbff
`define FAG_LOCK_PAGE 7'h7d
`define FAG_LOCK_BLOCK 3'h7
`define FAG_RESV_BASE 16'hfc00
`define FAG_SCRATCH_HI 9'h000
`define FAG_LIMIT_LO 8'h00
`define FAG_ZERO_BYTE 8'h00

`endif

// >>> core/fag_pkg.sv
// Purpose: Types and address decoding shared by the guard modules.
// Assumes: fag_cfg.svh supplies every number.
// Notes:   Decoders are functions because both modules use them.
`include "fag_cfg.svh"

package fag_pkg;

	// Debug-port operation
	typedef enum logic [1:0] {DBG_READ, DBG_WRITE, DBG_ERASE} fag_dbg_type;

	// Firmware operation
	typedef enum logic [1:0] {FW_FETCH, FW_CODE_READ, FW_XMOVE_WRITE} fag_fw_type;

	// Operation handed to the flash array
	typedef enum logic [1:0] {FL_READ, FL_WRITE, FL_ERASE_PAGE, FL_ERASE_ALL} fag_flop_type;

	// Reserved area above the lock bytes
	function automatic logic fag_reserved(input logic [15:0] a);
		return a >= `FAG_RESV_BASE;
	endfunction

	// Page that holds the lock bytes
	function automatic logic fag_lock_page(input logic [15:0] a);
		return a[15:9] == `FAG_LOCK_PAGE;
	endfunction

	// One of the two lock bytes
	function automatic logic fag_lock_byte(input logic [15:0] a);
		return (a == `FAG_WE_LOCK_ADDR) || (a == `FAG_RD_LOCK_ADDR);
	endfunction

endpackage

// >>> core/fag_chk_if.sv
// Purpose: Carries one access request to the policy checker and its verdict back.
// Assumes: Purely combinational between the two ends.
// Notes:   The guard drives the request, the checker the verdict.
`timescale 1ns/100ps

interface fag_chk_if;
	import fag_pkg::*;
	logic is_dbg; // Request comes from the debug port
	fag_dbg_type dbg_op; // Debug operation
	fag_fw_type fw_op; // Firmware operation
	logic [15:0] addr; // Target flash address
	logic [15:0] pc; // Firmware program counter
	logic [7:0] limit; // Access limit high byte
	logic [7:0] rd_lock; // Read lock byte
	logic [7:0] we_lock; // Write/erase lock byte
	logic [7:0] store; // Program store control
	logic [7:0] timing; // Flash timing control
	logic allow; // Access may proceed
	logic zero_read; // Answer zero without touching flash
	logic to_xram; // Write goes to data RAM
	fag_flop_type fl_op; // Flash operation to issue

	modport guard (output is_dbg, dbg_op, fw_op, addr, pc, limit, rd_lock, we_lock, store, timing,
		input allow, zero_read, to_xram, fl_op);
	modport policy (input is_dbg, dbg_op, fw_op, addr, pc, limit, rd_lock, we_lock, store, timing,
		output allow, zero_read, to_xram, fl_op);
endinterface

// >>> core/fag_policy.sv
// Purpose: Decides whether a debug or firmware flash access may proceed.
// Assumes: Inputs are stable for the cycle; no state kept here.
// Notes:   Reserved area is checked first on the debug path; firmware RAM and scratchpad routing come before it.
`timescale 1ns/100ps
`include "fag_cfg.svh"

module fag_policy (
	fag_chk_if.policy chk
);
	import fag_pkg::*;

	logic upper; // Code runs at or above the limit
	logic below; // Target lies below the limit
	logic rd_ok; // Block read-enabled for debug
	logic we_ok; // Block write/erase-enabled for debug
	logic lbyte; // Target is a lock byte
	logic scratch; // Firmware aims at the scratchpad

	// Partition and lock decode
	always_comb begin
		upper = chk.pc >= {chk.limit, `FAG_LIMIT_LO};
		below = chk.addr < {chk.limit, `FAG_LIMIT_LO};
		rd_ok = chk.rd_lock[chk.addr[15:13]]; // [R23]
		we_ok = chk.we_lock[chk.addr[15:13]]; // [R23]
		lbyte = fag_lock_byte(chk.addr);
		scratch = chk.store[`FAG_BIT_SCRATCH];
	end

	// Verdict
	always_comb begin
		chk.allow = 1'b0;
		chk.zero_read = 1'b0;
		chk.to_xram = 1'b0;
		chk.fl_op = FL_READ;
		if (chk.is_dbg) begin
			// Lock bytes restrict only this path [R6]
			if (fag_reserved(chk.addr)) begin
				chk.allow = 1'b0; // [R5]
			end else begin
				unique case (chk.dbg_op)
					DBG_READ: begin
						chk.allow = lbyte || rd_ok; // [R1] [R2]
					end
					DBG_WRITE: begin
						chk.allow = lbyte || we_ok; // [R1] [R2]
						chk.fl_op = FL_WRITE;
					end
					default: begin
						// Erase at a lock byte of a locked page wipes the whole device [R4]
						if (lbyte && !chk.we_lock[`FAG_LOCK_BLOCK]) begin
							chk.allow = 1'b1;
							chk.fl_op = FL_ERASE_ALL;
						end else begin
							chk.allow = we_ok; // [R1] [R3]
							chk.fl_op = FL_ERASE_PAGE;
						end
					end
				endcase
			end
		end else if (chk.fw_op == FW_XMOVE_WRITE && !chk.store[`FAG_BIT_PWRITE]) begin
			chk.allow = 1'b1; // [R19]
			chk.to_xram = 1'b1;
		end else if (scratch && chk.fw_op != FW_FETCH) begin
			// Scratchpad sits outside the main map; limit does not apply
			chk.allow = chk.fw_op != FW_XMOVE_WRITE || chk.timing[`FAG_BIT_SWWE]; // [R17] [R16]
			chk.fl_op = chk.fw_op == FW_XMOVE_WRITE ?
				(chk.store[`FAG_BIT_PERASE] ? FL_ERASE_PAGE : FL_WRITE) : FL_READ;
		end else if (fag_reserved(chk.addr)) begin
			chk.allow = 1'b0; // [R5]
		end else begin
			unique case (chk.fw_op)
				FW_FETCH: begin
					chk.allow = 1'b1; // [R12]
				end
				FW_CODE_READ: begin
					chk.allow = 1'b1; // [R7] [R11]
					chk.zero_read = upper && below; // [R22] [R10]
				end
				default: begin
					if (!chk.timing[`FAG_BIT_SWWE]) begin
						chk.allow = 1'b0; // [R16]
					end else if (upper && below) begin
						chk.allow = 1'b0; // [R10]
					end else if (chk.store[`FAG_BIT_PERASE]) begin
						chk.allow = !fag_lock_page(chk.addr); // [R8] [R18]
						chk.fl_op = FL_ERASE_PAGE;
					end else begin
						chk.allow = 1'b1; // [R9] [R7] [R11]
						chk.fl_op = FL_WRITE;
					end
				end
			endcase
		end
	end

endmodule

// >>> core/fag_guard.sv
// Purpose: Flash access guard: lock bytes, access limit and program store controls.
// Assumes: Flash array answers fl_rdata combinationally for fl_addr in the issue cycle.
// Notes:   One request in flight; request at edge 0, flash strobe cycle 1, answer cycle 2.
// Functional notes
// R1 - Debug: unlocked pages usable, locked pages refused
// R2 - Debug may always read and write lock bytes
// R3 - Debug erase of unlocked lock page allowed
// R4 - Locked lock page needs full device erase
// R5 - Reserved area refuses every access
// R6 - Lock bytes never restrict firmware
// R7 - Lower firmware reaches all but lock-page erase
// R8 - Firmware never erases the lock page
// R9 - Firmware may read and write lock page
// R10 - Upper firmware blocked below the limit
// R11 - Upper firmware free at or above limit
// R12 - Fetches below the limit always allowed
// R13 - One-shot bit turns sense amps off
// R14 - Read-always bit reads every cycle
// R15 - Timing reserved bits read zero
// R16 - Firmware write/erase needs enable bit
// R17 - Scratch select redirects to scratchpad sector
// R18 - Erase enable turns writes into page erase
// R19 - Write enable off sends writes to RAM
// R20 - Store control upper bits zero, reset zero
// R21 - Limit is byte times 256, write once
// R22 - Upper code read of lower returns zero
// R23 - Each lock bit governs one block
// R24 - Refusals change nothing and never stall
`timescale 1ns/100ps
`include "fag_cfg.svh"

module fag_guard (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic dbg_req,
	input wire fag_pkg::fag_dbg_type dbg_op,
	input wire logic [15:0] dbg_addr,
	input wire logic [7:0] dbg_wdata,
	input wire logic fw_req,
	input wire fag_pkg::fag_fw_type fw_op,
	input wire logic [15:0] fw_addr,
	input wire logic [15:0] fw_pc,
	input wire logic [7:0] fw_wdata,
	input wire logic [7:0] rd_lock_byte,
	input wire logic [7:0] we_lock_byte,
	input wire logic [7:0] fl_rdata,
	output logic fl_valid,
	output fag_pkg::fag_flop_type fl_op,
	output logic [15:0] fl_addr,
	output logic [7:0] fl_wdata,
	output logic fl_scratch,
	output logic fl_read,
	output logic sense_on,
	output logic xram_wr,
	output logic fw_ack,
	output logic dbg_ack,
	output logic rsp_denied,
	output logic [7:0] rsp_rdata
);
	import fag_pkg::*;

	// Whole state of the guard
	typedef struct packed {
		logic [7:0] timing; // Flash timing control
		logic [7:0] store; // Program store control
		logic [7:0] limit; // Access limit register
		logic limit_locked; // Limit already written since reset
		logic [7:0] sfr_rdata; // Register read answer
		logic issue; // A request sits in the issue stage
		logic iss_dbg; // It came from the debug port
		logic iss_deny; // It was refused
		logic iss_zero; // It answers zero without flash
		logic fl_valid; // Flash strobe
		fag_flop_type fl_op; // Flash operation
		logic [15:0] fl_addr; // Flash or RAM address
		logic [7:0] fl_wdata; // Flash or RAM data
		logic fl_scratch; // Scratchpad sector selected
		logic fl_read; // Sense strobe
		logic sense_on; // Sense amps powered
		logic xram_wr; // Data RAM write strobe
		logic fw_ack; // Firmware answer
		logic dbg_ack; // Debug answer
		logic rsp_denied; // Answer marks a refusal
		logic [7:0] rsp_rdata; // Answer data
	} fag_state_type;

	fag_state_type state; // Registered state
	fag_state_type next_state; // Value for the next edge
	fag_chk_if chk (); // Request to the checker
	logic take; // A request is accepted this cycle
	logic rd_issue; // Accepted request reads the array

	fag_policy u_policy (
		.chk(chk)
	);

	// Present the pending request; debug wins a tie, firmware simply waits
	always_comb begin
		chk.is_dbg = dbg_req;
		chk.dbg_op = dbg_op;
		chk.fw_op = fw_op;
		chk.addr = dbg_req ? dbg_addr : fw_addr;
		chk.pc = fw_pc;
		chk.limit = state.limit; // [R21]
		chk.rd_lock = rd_lock_byte;
		chk.we_lock = we_lock_byte;
		chk.store = state.store;
		chk.timing = state.timing;
	end

	// Next-state logic
	always_comb begin
		next_state = state;
		next_state.fl_valid = 1'b0;
		next_state.xram_wr = 1'b0;
		next_state.fw_ack = 1'b0;
		next_state.dbg_ack = 1'b0;
		next_state.issue = 1'b0;
		next_state.sfr_rdata = `FAG_ZERO_BYTE;
		// Only one request in flight, so a request held through its answer cycle is not taken twice
		take = !state.issue && !state.fw_ack && !state.dbg_ack && (dbg_req || fw_req);
		rd_issue = take && chk.allow && !chk.zero_read && !chk.to_xram && chk.fl_op == FL_READ;

		// Register writes
		if (sfr_wr) begin
			if (sfr_addr == `FAG_OFS_TIMING) begin
				next_state.timing = sfr_wdata & `FAG_MASK_TIMING; // [R15]
			end else if (sfr_addr == `FAG_OFS_STORE) begin
				next_state.store = sfr_wdata & `FAG_MASK_STORE; // [R20]
			end else if (sfr_addr == `FAG_OFS_LIMIT && !state.limit_locked) begin
				next_state.limit = sfr_wdata; // [R21]
				next_state.limit_locked = 1'b1;
			end
		end

		// Register reads; unmapped offsets answer zero
		if (sfr_rd) begin
			if (sfr_addr == `FAG_OFS_TIMING) begin
				next_state.sfr_rdata = state.timing; // [R15]
			end else if (sfr_addr == `FAG_OFS_STORE) begin
				next_state.sfr_rdata = state.store; // [R20]
			end else if (sfr_addr == `FAG_OFS_LIMIT) begin
				next_state.sfr_rdata = state.limit;
			end
		end

		// Issue stage: refused requests leave the array untouched [R24]
		if (take) begin
			next_state.issue = 1'b1;
			next_state.iss_dbg = dbg_req;
			next_state.iss_deny = !chk.allow;
			next_state.iss_zero = chk.zero_read; // [R22]
			next_state.fl_addr = chk.addr;
			next_state.fl_wdata = dbg_req ? dbg_wdata : fw_wdata;
			next_state.fl_op = chk.fl_op;
			// Fetches and data RAM writes keep the full address even with the scratchpad selected
			next_state.fl_scratch = !dbg_req && chk.fw_op != FW_FETCH && !chk.to_xram
				&& state.store[`FAG_BIT_SCRATCH]; // [R17]
			if (next_state.fl_scratch) begin
				// Only the low seven bits reach the scratchpad
				next_state.fl_addr = {`FAG_SCRATCH_HI, chk.addr[6:0]}; // [R17]
			end
			if (chk.to_xram) begin
				next_state.xram_wr = 1'b1; // [R19]
			end else if (chk.allow && !chk.zero_read) begin
				next_state.fl_valid = 1'b1; // [R1] [R18]
			end
		end

		// Sense control: every-cycle mode strobes regardless of traffic
		next_state.fl_read = state.timing[`FAG_BIT_EVERY] || rd_issue; // [R14]
		next_state.sense_on = !state.timing[`FAG_BIT_ONESHOT] || next_state.fl_read; // [R13]

		// Answer stage, never held back by a refusal
		if (state.issue) begin
			next_state.dbg_ack = state.iss_dbg;
			next_state.fw_ack = !state.iss_dbg; // [R24]
			next_state.rsp_denied = state.iss_deny;
			next_state.rsp_rdata = (state.fl_valid && state.fl_op == FL_READ) ? fl_rdata : `FAG_ZERO_BYTE; // [R22]
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= '0;
			state.timing <= `FAG_RST_TIMING; // [R13]
			state.store <= `FAG_RST_STORE; // [R20]
			state.limit <= `FAG_RST_LIMIT;
			state.sense_on <= 1'b1;
			state.fl_op <= FL_READ;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Outputs straight from the state register
	always_comb begin
		sfr_rdata = state.sfr_rdata;
		fl_valid = state.fl_valid;
		fl_op = state.fl_op;
		fl_addr = state.fl_addr;
		fl_wdata = state.fl_wdata;
		fl_scratch = state.fl_scratch;
		fl_read = state.fl_read;
		sense_on = state.sense_on;
		xram_wr = state.xram_wr;
		fw_ack = state.fw_ack;
		dbg_ack = state.dbg_ack;
		rsp_denied = state.rsp_denied;
		rsp_rdata = state.rsp_rdata;
	end

	// Checks; a stall by ce aborts an attempt rather than failing it
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst || !ce);

	AST_RESV_NEVER_ISSUED: assert property (fl_valid && fl_op != FL_ERASE_ALL && !fl_scratch |-> !fag_reserved(fl_addr)) // [R5]
		else $error("reserved area reached the flash array");
	AST_FW_NO_LOCK_ERASE: assert property ((fl_valid && fl_op == FL_ERASE_PAGE && !fl_scratch) ##1 fw_ack
		|-> !fag_lock_page($past(fl_addr))) // [R8]
		else $error("firmware erased the lock page");
	AST_FW_NEEDS_ENABLE: assert property (take && !dbg_req && fw_op == FW_XMOVE_WRITE && state.store[`FAG_BIT_PWRITE]
		&& !state.timing[`FAG_BIT_SWWE] |=> !fl_valid ##1 (fw_ack && rsp_denied)) // [R16]
		else $error("firmware write passed without enable");
	AST_LIMIT_ONCE: assert property (sfr_wr && sfr_addr == `FAG_OFS_LIMIT && state.limit_locked
		|=> $stable(state.limit)) // [R21]
		else $error("limit register took a second write");
	AST_ZERO_READ: assert property (take && !dbg_req && fw_op == FW_CODE_READ && !state.store[`FAG_BIT_SCRATCH]
		&& fw_pc >= {state.limit, 8'h00} && fw_addr < {state.limit, 8'h00} && !fag_reserved(fw_addr)
		|=> !fl_valid ##1 (fw_ack && !rsp_denied && rsp_rdata == 8'h00)) // [R22]
		else $error("protected code read did not answer zero");
	AST_DBG_LOCKED: assert property (take && dbg_req && dbg_op == DBG_READ && !fag_lock_byte(dbg_addr)
		&& !rd_lock_byte[dbg_addr[15:13]] |-> ##2 (dbg_ack && rsp_denied)) // [R1]
		else $error("debug read of locked block passed");
	AST_ONESHOT_OFF: assert property (!state.timing[`FAG_BIT_ONESHOT] |=> sense_on) // [R13]
		else $error("sense amps dropped with one-shot off");
	// A timing write in the same cycle may end read-always mode, so the second cycle is not owed then
	AST_READ_EVERY: assert property (state.timing[`FAG_BIT_EVERY] && !(sfr_wr && sfr_addr == `FAG_OFS_TIMING)
		|=> fl_read [*2]) // [R14]
		else $error("read-always mode missed a cycle");
	AST_RSV_BITS: assert property (sfr_rd && (sfr_addr == `FAG_OFS_TIMING || sfr_addr == `FAG_OFS_STORE)
		|=> sfr_rdata[5:3] == 3'h0) // [R15] [R20]
		else $error("reserved register bits read nonzero");
	AST_XRAM_ROUTE: assert property (take && !dbg_req && fw_op == FW_XMOVE_WRITE && !state.store[`FAG_BIT_PWRITE]
		|=> xram_wr && !fl_valid ##1 fw_ack) // [R19]
		else $error("write with store disabled missed RAM");
	AST_ERASE_MODE: assert property (take && !dbg_req && fw_op == FW_XMOVE_WRITE && state.store[1:0] == 2'h3
		&& state.timing[0] && !fag_lock_page(fw_addr) && !fag_reserved(fw_addr)
		&& !(fw_pc >= {state.limit, 8'h00} && fw_addr < {state.limit, 8'h00})
		|=> fl_valid && fl_op == FL_ERASE_PAGE) // [R18]
		else $error("erase mode did not erase the page");

	COV_DBG_FULL_ERASE: cover property (fl_valid && fl_op == FL_ERASE_ALL);
	COV_FW_DENIED: cover property (fw_ack && rsp_denied);
	COV_DBG_READ: cover property (dbg_ack && !rsp_denied);

endmodule

// >>> verification/fag_flash_model.sv
// Purpose: Program flash array model facing the guard.
// Assumes: Byte n starts as n[7:0]; lock bytes and scratchpad start erased.
// Notes:   Writes overwrite outright, so a test may reuse a location.
`timescale 1ns/100ps
`include "fag_cfg.svh"

module fag_flash_model
	import fag_pkg::*;
(
	input wire logic clock,
	input wire fag_pkg::fag_flop_type fl_op,
	input wire logic fl_valid,
	input wire logic [15:0] fl_addr,
	input wire logic [7:0] fl_wdata,
	input wire logic fl_scratch,
	output logic [7:0] fl_rdata,
	output logic [7:0] rd_lock_byte,
	output logic [7:0] we_lock_byte
);
	logic [7:0] mem [0:65535]; // Main array
	logic [7:0] pad [0:127]; // Scratchpad sector
	// Address-derived content keeps every expected byte computable
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0];
		end
		for (int i = 0; i < 128; i++) begin
			pad[i] = 8'hff;
		end
		mem[`FAG_WE_LOCK_ADDR] = 8'hff;
		mem[`FAG_RD_LOCK_ADDR] = 8'hff;
	end
	// Acts only on the one-cycle strobe; erased bytes read all ones
	always @(posedge clock) begin
		if (fl_valid && fl_op == FL_WRITE && fl_scratch) begin
			pad[fl_addr[6:0]] = fl_wdata;
		end else if (fl_valid && fl_op == FL_WRITE) begin
			mem[fl_addr] = fl_wdata;
		end else if (fl_valid && fl_op == FL_ERASE_PAGE) begin
			for (int i = 0; i < 512; i++) begin
				mem[{fl_addr[15:9], i[8:0]}] = 8'hff;
			end
		end else if (fl_valid && fl_op == FL_ERASE_ALL) begin
			for (int i = 0; i < 65536; i++) begin
				mem[i] = 8'hff;
			end
		end
	end
	// Data follows the address with no clock, as the guard samples it in the strobe cycle
	assign fl_rdata = fl_scratch ? pad[fl_addr[6:0]] : mem[fl_addr];
	assign rd_lock_byte = mem[`FAG_RD_LOCK_ADDR];
	assign we_lock_byte = mem[`FAG_WE_LOCK_ADDR];
endmodule

// >>> verification/flash_access_guard_test.sv
// Purpose: Self-checking bench for the flash access guard.
// Assumes: One flash request in flight; flash model answers without a clock.
// Notes:   Drivers queue expectations; monitors compare when answers appear.
`timescale 1ns/100ps
`include "fag_cfg.svh"

module flash_access_guard_test;
	import fag_pkg::*;
	localparam logic [15:0] lo = 16'h1000; // Program counter in the lower partition
	localparam logic [15:0] hi = 16'h8000; // Program counter in the upper partition
	logic clock, rst, ce, sfr_wr, sfr_rd, dbg_req, fw_req, rd_seen; // Controls
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, dbg_wdata, fw_wdata; // Register and write data
	logic [7:0] fl_rdata, rd_lock_byte, we_lock_byte, fl_wdata, rsp_rdata; // Array side and answer
	logic [15:0] dbg_addr, fw_addr, fw_pc, fl_addr, lfsr; // Addresses and random state
	logic fl_valid, fl_scratch, fl_read, sense_on, xram_wr, fw_ack, dbg_ack, rsp_denied; // Outputs
	fag_dbg_type dbg_op; // Debug operation
	fag_fw_type fw_op; // Firmware operation
	fag_flop_type fl_op; // Operation sent to the array
	int fails, comparisons, strobes; // Tallies
	logic [9:0] rsp_q [$]; // Expected answer: debug side, refusal, data
	logic [7:0] reg_q [$]; // Expected register read data

	fag_guard u_fag_guard (.clock, .rst, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
		.dbg_req, .dbg_op, .dbg_addr, .dbg_wdata, .fw_req, .fw_op, .fw_addr, .fw_pc, .fw_wdata,
		.rd_lock_byte, .we_lock_byte, .fl_rdata, .fl_valid, .fl_op, .fl_addr, .fl_wdata, .fl_scratch,
		.fl_read, .sense_on, .xram_wr, .fw_ack, .dbg_ack, .rsp_denied, .rsp_rdata);
	fag_flash_model u_fag_flash_model (.clock, .fl_op, .fl_valid, .fl_addr, .fl_wdata, .fl_scratch,
		.fl_rdata, .rd_lock_byte, .we_lock_byte);

	// Free-running 250 MHz clock
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	// Random source for addresses and data
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// Counts a check and reports a mismatch at once
	task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t ns: expected %h, got %h", $time, exp, got);
		end
	endtask
	// Flash answer check
	task automatic cmp_rsp(input logic [9:0] exp, input logic [9:0] got);
		cmp({6'h00, exp}, {6'h00, got});
	endtask
	// Register read check
	task automatic cmp_reg(input logic [7:0] exp, input logic [7:0] got);
		cmp({8'h00, exp}, {8'h00, got});
	endtask

	// Marks a taken register read and counts array or RAM strobes
	always @(posedge clock) begin
		rd_seen <= sfr_rd && ce && !rst;
		if (fl_valid || xram_wr) begin
			strobes <= strobes + 1;
		end
	end
	// Compares settled answers with the oldest note
	always @(negedge clock) begin
		if (rd_seen) begin
			cmp_reg(reg_q.pop_front(), sfr_rdata);
		end
		if (fw_ack || dbg_ack) begin
			cmp_rsp(rsp_q.pop_front(), {dbg_ack, rsp_denied, rsp_rdata});
		end
	end

	// One register access; a read notes its expected answer
	task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
		if (!wr) reg_q.push_back(d);
		@(posedge clock);
		#1;
		{sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, wr, !wr};
		@(posedge clock);
		#1;
		{sfr_wr, sfr_rd} = 2'h0;
	endtask

	// Holds a request until its answer; released qualifiers are scrambled so stale values never help
	task automatic req(input logic side, input logic [1:0] op, input logic [15:0] a, input logic [15:0] pc,
		input logic [7:0] wd, input logic den, input logic [7:0] rd);
		int n;
		int s;
		n = 0;
		s = strobes;
		rsp_q.push_back({side, den, rd});
		@(posedge clock);
		#1;
		dbg_op = fag_dbg_type'(op);
		fw_op = fag_fw_type'(op);
		{dbg_addr, fw_addr, fw_pc, dbg_wdata, fw_wdata, dbg_req, fw_req} = {a, a, pc, wd, wd, side, !side};
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (fw_ack !== 1'h1 && dbg_ack !== 1'h1 && n < 10);
		cmp(16'h0002, n[15:0]);
		@(posedge clock);
		#1;
		{dbg_req, fw_req, dbg_addr, fw_addr} = {2'h0, ~a, ~a};
		if (den) cmp(s[15:0], strobes[15:0]);
	endtask
	// Firmware request
	task automatic fw(input fag_fw_type op, input logic [15:0] a, input logic [15:0] pc, input logic [7:0] wd,
		input logic den, input logic [7:0] rd);
		req(1'h0, op, a, pc, wd, den, rd);
	endtask
	// Debug-port request
	task automatic dbg(input fag_dbg_type op, input logic [15:0] a, input logic [7:0] wd, input logic den,
		input logic [7:0] rd);
		req(1'h1, op, a, 16'h0000, wd, den, rd);
	endtask

	// Lets the timing register land, then looks at the sense outputs
	task automatic sense(input logic rd_exp, input logic on_exp);
		repeat (2) begin
			@(posedge clock);
			#1;
		end
		cmp({15'h0000, rd_exp}, {15'h0000, fl_read});
		cmp({15'h0000, on_exp}, {15'h0000, sense_on});
	endtask

	// Prints the tallies and the verdict, then ends the run
	task automatic results;
		$display("Totals: %0d comparisons, %0d fails", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length
	initial begin
		#20000;
		fails++;
		results();
	end

	// Main sequence
	initial begin
		{rst, ce, sfr_wr, sfr_rd, dbg_req, fw_req, rd_seen} = {2'h3, 5'h00};
		{sfr_addr, sfr_wdata, dbg_wdata, fw_wdata, dbg_addr, fw_addr, fw_pc} = 80'h0;
		dbg_op = DBG_READ;
		fw_op = FW_FETCH;
		{fails, comparisons, strobes} = {32'h0, 32'h0, 32'h0};
		lfsr = 16'h0032;
		repeat (6) @(posedge clock);
		#1;
		rst = 1'h0;
		reg_op(1'h0, `FAG_OFS_STORE, 8'h00);
		reg_op(1'h0, `FAG_OFS_TIMING, 8'h80);
		reg_op(1'h0, `FAG_OFS_LIMIT, 8'h00);
		reg_op(1'h0, 8'h10, 8'h00);
		reg_op(1'h1, `FAG_OFS_STORE, 8'hff);
		reg_op(1'h0, `FAG_OFS_STORE, 8'h07);
		reg_op(1'h1, `FAG_OFS_TIMING, 8'hc1);
		reg_op(1'h0, `FAG_OFS_TIMING, 8'hc1);
		sense(1'h1, 1'h1);
		sense(1'h1, 1'h1);
		reg_op(1'h1, `FAG_OFS_TIMING, 8'h00);
		sense(1'h0, 1'h1);
		reg_op(1'h1, `FAG_OFS_TIMING, 8'h80);
		sense(1'h0, 1'h0);
		reg_op(1'h1, `FAG_OFS_STORE, 8'h00);
		reg_op(1'h1, `FAG_OFS_LIMIT, 8'h40);
		reg_op(1'h1, `FAG_OFS_LIMIT, 8'h80);
		reg_op(1'h0, `FAG_OFS_LIMIT, 8'h40);
		fw(FW_CODE_READ, 16'h5678, lo, 8'h00, 1'h0, 8'h78);
		fw(FW_CODE_READ, 16'h1234, hi, 8'h00, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'h3fff, hi, 8'h00, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'h4001, hi, 8'h00, 1'h0, 8'h01);
		fw(FW_FETCH, 16'h0123, hi, 8'h00, 1'h0, 8'h23);
		fw(FW_XMOVE_WRITE, 16'h5011, lo, 8'h5a, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'h5011, lo, 8'h00, 1'h0, 8'h11);
		reg_op(1'h1, `FAG_OFS_STORE, 8'h01);
		fw(FW_XMOVE_WRITE, 16'h5011, lo, 8'h5a, 1'h1, 8'h00);
		fw(FW_CODE_READ, 16'h5011, lo, 8'h00, 1'h0, 8'h11);
		reg_op(1'h1, `FAG_OFS_TIMING, 8'h81);
		fw(FW_XMOVE_WRITE, 16'h5011, lo, 8'h5a, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'h5011, lo, 8'h00, 1'h0, 8'h5a);
		fw(FW_XMOVE_WRITE, 16'h1022, hi, 8'h33, 1'h1, 8'h00);
		fw(FW_CODE_READ, 16'h1022, lo, 8'h00, 1'h0, 8'h22);
		fw(FW_XMOVE_WRITE, 16'h6000, hi, 8'h66, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'h6000, hi, 8'h00, 1'h0, 8'h66);
		fw(FW_XMOVE_WRITE, 16'hfa20, lo, 8'h11, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'hfa20, lo, 8'h00, 1'h0, 8'h11);
		reg_op(1'h1, `FAG_OFS_STORE, 8'h03);
		fw(FW_XMOVE_WRITE, 16'h6010, lo, 8'h12, 1'h0, 8'h00);
		fw(FW_XMOVE_WRITE, 16'hfa10, lo, 8'h00, 1'h1, 8'h00);
		fw(FW_XMOVE_WRITE, 16'hfa10, hi, 8'h00, 1'h1, 8'h00);
		fw(FW_XMOVE_WRITE, 16'h1000, hi, 8'h00, 1'h1, 8'h00);
		fw(FW_CODE_READ, 16'h6010, lo, 8'h00, 1'h0, 8'hff);
		fw(FW_CODE_READ, 16'h61ff, lo, 8'h00, 1'h0, 8'hff);
		fw(FW_CODE_READ, 16'h6200, lo, 8'h00, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'hfa20, lo, 8'h00, 1'h0, 8'h11);
		fw(FW_CODE_READ, 16'hfc10, lo, 8'h00, 1'h1, 8'h00);
		reg_op(1'h1, `FAG_OFS_STORE, 8'h05);
		fw(FW_XMOVE_WRITE, 16'h0010, lo, 8'ha5, 1'h0, 8'h00);
		reg_op(1'h1, `FAG_OFS_STORE, 8'h04);
		fw(FW_CODE_READ, 16'h0010, lo, 8'h00, 1'h0, 8'ha5);
		reg_op(1'h1, `FAG_OFS_STORE, 8'h01);
		// A write while the clock enable is low must leave the register alone
		ce = 1'h0;
		reg_op(1'h1, `FAG_OFS_STORE, 8'h03);
		ce = 1'h1;
		reg_op(1'h0, `FAG_OFS_STORE, 8'h01);
		fw(FW_CODE_READ, 16'h0010, lo, 8'h00, 1'h0, 8'h10);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			fw(FW_CODE_READ, {2'h2, lfsr[13:0]}, 16'h9000, lfsr[15:8], 1'h0, lfsr[7:0]);
		end
		dbg(DBG_READ, 16'h1234, 8'h00, 1'h0, 8'h34);
		dbg(DBG_WRITE, 16'hfbfe, 8'hfe, 1'h0, 8'h00);
		dbg(DBG_READ, 16'h0100, 8'h00, 1'h0, 8'h00);
		dbg(DBG_WRITE, 16'h0100, 8'h77, 1'h1, 8'h00);
		dbg(DBG_ERASE, 16'h0100, 8'h00, 1'h1, 8'h00);
		dbg(DBG_WRITE, 16'hfbff, 8'hfe, 1'h0, 8'h00);
		dbg(DBG_READ, 16'h0100, 8'h00, 1'h1, 8'h00);
		dbg(DBG_READ, 16'hfbff, 8'h00, 1'h0, 8'hfe);
		dbg(DBG_READ, 16'h2100, 8'h00, 1'h0, 8'h00);
		fw(FW_CODE_READ, 16'h0100, lo, 8'h00, 1'h0, 8'h00);
		fw(FW_XMOVE_WRITE, 16'h0100, lo, 8'h77, 1'h0, 8'h00);
		dbg(DBG_READ, 16'hfc10, 8'h00, 1'h1, 8'h00);
		dbg(DBG_ERASE, 16'hfbfe, 8'h00, 1'h0, 8'h00);
		dbg(DBG_READ, 16'h0100, 8'h00, 1'h0, 8'h77);
		dbg(DBG_WRITE, 16'hfbfe, 8'h7e, 1'h0, 8'h00);
		dbg(DBG_ERASE, 16'hfa00, 8'h00, 1'h1, 8'h00);
		dbg(DBG_WRITE, 16'hfbfe, 8'h00, 1'h0, 8'h00);
		dbg(DBG_ERASE, 16'hfbff, 8'h00, 1'h0, 8'h00);
		dbg(DBG_READ, 16'h1234, 8'h00, 1'h0, 8'hff);
		dbg(DBG_READ, 16'hfbfe, 8'h00, 1'h0, 8'hff);
		repeat (4) @(posedge clock);
		results();
	end
endmodule
